//--- isf_status_top.sv
// status flag logic of the i2c interface with its apb register file
// assumes master-role hooks come from logic on core_clk, lines from pins
//
// Operation
// - direction zero keeps data line released
// - direction one drives latch after ninth fall
// - set direction on generated start or rx one
// - clear direction on stop, controls, loss, reset
// - clear direction on master zero, slave start/zero
// - wait release in ninth clock frees line
// - ack flag set on low ninth rising
// - ack flag cleared by stop, next byte, controls
// - start flag set on start condition
// - start flag cleared when the byte after the address starts
// - stop flag set on stop condition
// - stop flag held until next address byte
// - exit bit six, enable bit seven of control
// - direction status bit three, wait bit five
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module isf_status_top (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial lines, open drain, enable low while driving
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOutEn_n,
  // hooks from the transfer engine
  input wire logic masterRole,
  input wire logic startGen,
  input wire logic arbLossFlag,
  input wire logic shiftOutLatch,
  // results
  output logic waitCancel,
  output logic irq
);
  import isf_pkg::*;

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  logic sclLvl;
  logic sdaLvl;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic [7:0] ctrl_reg;
  logic exitPulse_reg;
  logic waitPulse_reg;
  logic enPrev_reg;
  logic arbPrev_reg;
  logic [3:0] bitCnt_reg;
  logic [3:0] bitCnt_next;
  logic firstByte_reg;
  logic firstByte_next;
  logic dir_reg;
  logic dir_next;
  logic drvOk_reg;
  logic drvOk_next;
  logic ack_reg;
  logic ack_next;
  logic std_reg;
  logic std_next;
  logic spd_reg;
  logic spd_next;
  logic [2:0] irqStat_reg;
  logic [2:0] irqStat_next;
  logic [2:0] irqMask_reg;
  logic [2:0] irqEvt;
  logic [31:0] rdMux;
  logic rdHit;

  // -------------------------------------------------------------
  // line watcher
  // -------------------------------------------------------------
  isf_line_watch uWatch (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sclLvl(sclLvl),
    .sdaLvl(sdaLvl),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startDet(startDet),
    .stopDet(stopDet)
  );

  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  // zero wait state: pready rises in the access cycle after setup
  wire apbSetup = psel & ~penable;
  wire apbDone = psel & penable & pready;
  wire wrEn = apbDone & pwrite;
  wire selCtrl = (paddr == OFS_CTRL);
  wire selStat = (paddr == OFS_STAT);
  wire selIrqStat = (paddr == OFS_IRQ_STAT);
  wire selIrqMask = (paddr == OFS_IRQ_MASK);
  wire wrCtrl = wrEn & selCtrl;
  wire wrIrqStat = wrEn & selIrqStat;
  wire wrIrqMask = wrEn & selIrqMask;
  assign rdHit = selCtrl | selStat | selIrqStat | selIrqMask;

  // -------------------------------------------------------------
  // control events
  // -------------------------------------------------------------
  wire ifEnable = ctrl_reg[CTRL_IF_ENABLE];
  wire enFall = enPrev_reg & ~ifEnable;
  wire arbRise = arbLossFlag & ~arbPrev_reg;
  // wait release counts only inside the ninth clock with direction set
  wire ninthWin = (bitCnt_reg == CNT_NINTH);
  wire waitCancelEvt = waitPulse_reg & dir_reg & ninthWin;
  // bus events are ignored while the interface is off
  wire busStart = ifEnable & startDet;
  wire busStop = ifEnable & stopDet;
  wire rise = ifEnable & sclRise;
  wire fall = ifEnable & sclFall;
  wire riseFirst = rise & ((bitCnt_reg == CNT_NINTH) | (bitCnt_reg == CNT_IDLE));
  wire riseDir = rise & (bitCnt_reg == CNT_DIR_BIT) & firstByte_reg;
  wire riseAck = rise & (bitCnt_reg == CNT_ACK_BIT);
  wire fallNinth = fall & ninthWin;

  // -------------------------------------------------------------
  // bit counter and address byte tracking
  // -------------------------------------------------------------
  // counter holds rising edges seen in the current byte, 9 means ack done
  assign bitCnt_next = (busStart | busStop | ~ifEnable) ? CNT_IDLE :
                       riseFirst ? CNT_FIRST :
                       rise ? 4'(bitCnt_reg + 4'h1) : bitCnt_reg;
  assign firstByte_next = busStart ? 1'b1 :
                          (fallNinth | busStop | ~ifEnable) ? 1'b0 : firstByte_reg;

  // -------------------------------------------------------------
  // direction flag
  // -------------------------------------------------------------
  // sets win over same-cycle clears so no event is lost
  wire dirSet = (masterRole & startGen & ifEnable) |
                (~masterRole & riseDir & sdaLvl);
  wire dirClrCommon = busStop | exitPulse_reg | waitCancelEvt | enFall |
                      arbRise;
  wire dirClrRole = masterRole ? (riseDir & ~shiftOutLatch) :
                    (busStart | (riseDir & ~sdaLvl));
  assign dir_next = dirSet | (dir_reg & ~(dirClrCommon | dirClrRole));
  // output goes live from the falling edge of the first byte's ninth clock
  assign drvOk_next = ~dir_next ? 1'b0 :
                      (fallNinth & firstByte_reg) ? 1'b1 : drvOk_reg;

  // -------------------------------------------------------------
  // ack, start and stop flags
  // -------------------------------------------------------------
  wire ackSet = riseAck & ~sdaLvl;
  wire ackClr = busStop | riseFirst | exitPulse_reg | enFall;
  assign ack_next = ackSet | (ack_reg & ~ackClr);
  wire stdClr = busStop | (riseFirst & ~firstByte_reg) | exitPulse_reg |
                enFall;
  assign std_next = busStart | (std_reg & ~stdClr);
  // stop flag survives a new start until the address byte clocks in
  wire spdClr = (riseFirst & firstByte_reg) | enFall;
  assign spd_next = busStop | (spd_reg & ~spdClr);

  // -------------------------------------------------------------
  // interrupt status, write one to clear, event wins
  // -------------------------------------------------------------
  assign irqEvt = {ackSet, busStart, busStop};
  assign irqStat_next = irqEvt |
                        (irqStat_reg & ~(wrIrqStat ? pwdata[2:0] : IRQ_RESET));

  // -------------------------------------------------------------
  // read mux, status reads have no side effects
  // -------------------------------------------------------------
  assign rdMux = selCtrl ? {24'h000000, ctrl_reg} :
                 selStat ? {28'h0000000, dir_reg, ack_reg, std_reg, spd_reg} :
                 selIrqStat ? {29'h00000000, irqStat_reg} :
                 selIrqMask ? {29'h00000000, irqMask_reg} : 32'h00000000;

  // -------------------------------------------------------------
  // apb response registers
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clkEn) begin
      pready <= apbSetup;
      pslverr <= apbSetup & ~rdHit;
      prdata <= apbSetup ? rdMux : prdata;
    end
  end

  // -------------------------------------------------------------
  // control register, exit and wait bits act as one-cycle strobes
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RESET;
      exitPulse_reg <= 1'b0;
      waitPulse_reg <= 1'b0;
      irqMask_reg <= IRQ_RESET;
    end else if (clkEn) begin
      // strobe bits never stick, so a later write can retrigger them
      ctrl_reg[CTRL_IF_ENABLE] <= wrCtrl ? pwdata[CTRL_IF_ENABLE] :
                                  ctrl_reg[CTRL_IF_ENABLE];
      exitPulse_reg <= wrCtrl & pwdata[CTRL_EXIT_COMM];
      waitPulse_reg <= wrCtrl & pwdata[CTRL_WAIT_REL];
      irqMask_reg <= wrIrqMask ? pwdata[2:0] : irqMask_reg;
    end
  end

  // -------------------------------------------------------------
  // flag and sequence state
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      enPrev_reg <= 1'b0;
      arbPrev_reg <= 1'b0;
      bitCnt_reg <= CNT_IDLE;
      firstByte_reg <= 1'b0;
      dir_reg <= 1'b0;
      drvOk_reg <= 1'b0;
      ack_reg <= 1'b0;
      std_reg <= 1'b0;
      spd_reg <= 1'b0;
      irqStat_reg <= IRQ_RESET;
    end else if (clkEn) begin
      enPrev_reg <= ifEnable;
      arbPrev_reg <= arbLossFlag;
      bitCnt_reg <= bitCnt_next;
      firstByte_reg <= firstByte_next;
      dir_reg <= dir_next;
      drvOk_reg <= drvOk_next;
      ack_reg <= ack_next;
      std_reg <= std_next;
      spd_reg <= spd_next;
      irqStat_reg <= irqStat_next;
    end
  end

  // -------------------------------------------------------------
  // pin and interrupt outputs
  // -------------------------------------------------------------
  // open drain: only a zero is ever driven, a one is a release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sdaOut <= 1'b0;
      sdaOutEn_n <= 1'b1;
      waitCancel <= 1'b0;
      irq <= 1'b0;
    end else if (clkEn) begin
      sdaOut <= 1'b0;
      sdaOutEn_n <= ~(dir_next & drvOk_next & ~shiftOutLatch);
      waitCancel <= waitCancelEvt;
      irq <= |(irqStat_next & irqMask_reg);
    end
  end

endmodule // isf_status_top
`default_nettype wire

//--- isf_pkg.sv
// shared constants of the i2c status flag block
// assumes a 32-bit apb bus and byte addresses of aligned words
package isf_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

  // ----------------------------------------------------------------
  // serial_bus_control fields
  // ----------------------------------------------------------------
  localparam int CTRL_WAIT_REL = 5;
  localparam int CTRL_EXIT_COMM = 6;
  localparam int CTRL_IF_ENABLE = 7;

  // ----------------------------------------------------------------
  // serial_bus_status fields
  // ----------------------------------------------------------------
  localparam int STAT_STOP = 0;
  localparam int STAT_START = 1;
  localparam int STAT_ACK = 2;
  localparam int STAT_DIR = 3;

  // ----------------------------------------------------------------
  // interrupt status fields
  // ----------------------------------------------------------------
  localparam int IRQ_STOP = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_ACK = 2;

  // ----------------------------------------------------------------
  // values after reset and clock counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [3:0] CNT_IDLE = 4'h0;
  localparam logic [3:0] CNT_DIR_BIT = 4'h7;
  localparam logic [3:0] CNT_ACK_BIT = 4'h8;
  localparam logic [3:0] CNT_NINTH = 4'h9;
  localparam logic [3:0] CNT_FIRST = 4'h1;

endpackage : isf_pkg

//--- isf_line_watch.sv
// two-stage synchronisers for the bus lines plus edge and condition finder
// assumes lines come from pins, asynchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
module isf_line_watch (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // raw lines
  input wire logic sclIn,
  input wire logic sdaIn,
  // filtered results
  output logic sclLvl,
  output logic sdaLvl,
  output logic sclRise,
  output logic sclFall,
  output logic startDet,
  output logic stopDet
);
  import isf_pkg::*;

  logic sclMeta_reg;
  logic sdaMeta_reg;
  logic sclSync_reg;
  logic sdaSync_reg;

  // -------------------------------------------------------------
  // synchronisers, idle high like the pulled-up bus
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclMeta_reg <= 1'b1;
      sdaMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      sclLvl <= 1'b1;
      sdaLvl <= 1'b1;
    end else if (clkEn) begin
      sclMeta_reg <= sclIn;
      sdaMeta_reg <= sdaIn;
      sclSync_reg <= sclMeta_reg;
      sdaSync_reg <= sdaMeta_reg;
      sclLvl <= sclSync_reg;
      sdaLvl <= sdaSync_reg;
    end
  end

  // edges compare the second stage against the held level
  assign sclRise = sclSync_reg & ~sclLvl;
  assign sclFall = ~sclSync_reg & sclLvl;
  // start: data falls while clock stays high; stop: data rises
  assign startDet = sclSync_reg & sclLvl & sdaLvl & ~sdaSync_reg;
  assign stopDet = sclSync_reg & sclLvl & ~sdaLvl & sdaSync_reg;

endmodule // isf_line_watch
`default_nettype wire

//--- isf_status_properties.sv
// port checker of the i2c status flag block
// assumes it is bound onto isf_status_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module isf_status_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // line side
  input wire logic sclIn,
  input wire logic sdaOutEn_n,
  input wire logic waitCancel,
  input wire logic irq
);
  // four aligned words from zero are mapped
  wire mapped = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_ready_setup: assert property (psel && !penable && clkEn |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  // reset must leave the line released whatever came before
  a_idle_reset: assert property (disable iff (1'b0)
      sys_rst && clkEn |=> sdaOutEn_n && !irq && !pready && !waitCancel)
    else $error("outputs not idle after reset");
  a_drive_low_clock: assert property ($fell(sdaOutEn_n) |-> !sclIn)
    else $error("data drive began with clock high");
  a_wait_frees: assert property (waitCancel |-> ##[0:2] sdaOutEn_n)
    else $error("line not freed after wait release");
  a_wait_single: assert property (waitCancel |=> !waitCancel)
    else $error("wait cancel longer than one cycle");
  // main scenarios reached
  cover property (waitCancel);
  cover property ($rose(irq));
  cover property (pready && pslverr);
endmodule // isf_status_properties
bind isf_status_top isf_status_properties isf_status_properties_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn),
  .sdaOutEn_n(sdaOutEn_n), .waitCancel(waitCancel), .irq(irq));
`default_nettype wire

//--- isf_bus_master_model.sv
// behavioural far-side i2c master driving clock and data
// assumes open-drain lines with pull-ups, 1 means released
`timescale 1ns/1ns
`default_nettype none
module isf_bus_master_model (
  // open-drain drives
  output logic sclLine,
  output logic sdaDrv
);
  // idle bus: both released, clock stands still between frames
  initial begin
    sclLine = 1'b1;
    sdaDrv = 1'b1;
  end
  // data falls while the clock is high
  task automatic start_cond();
    sdaDrv = 1'b0;
    #63 sclLine = 1'b0;
  endtask
  // eight bits msb first, then the ack slot; 125 ns per clock
  task automatic send_byte(input logic [7:0] val, input logic ackLow);
    logic [8:0] bits;
    bits = {val, ~ackLow};
    for (int i = 8; i >= 0; i--) begin
      #20 sdaDrv = bits[i];
      #42 sclLine = 1'b1;
      #63 sclLine = 1'b0;
    end
    #20 sdaDrv = 1'b1; // hand the line over once the ack slot is over
  endtask
  // data rises while the clock is high
  task automatic stop_cond();
    #20 sdaDrv = 1'b0;
    #42 sclLine = 1'b1;
    #40 sdaDrv = 1'b1;
  endtask
endmodule // isf_bus_master_model
`default_nettype wire

//--- i2c_status_flag_logic_tb.sv
// self-checking bench of the i2c status flag block
// assumes the far-side master model and the bound port checker
`timescale 1ns/1ns
`default_nettype none
module i2c_status_flag_logic_tb;
  import isf_pkg::*;
  localparam logic [31:0] EN = 32'h1 << CTRL_IF_ENABLE;
  localparam logic [31:0] WR = 32'h1 << CTRL_WAIT_REL;
  localparam logic [31:0] EX = 32'h1 << CTRL_EXIT_COMM;
  logic core_clk, sys_rst, clkEn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sclLine, sdaDrv, sdaOut, sdaOutEn_n, masterRole, startGen, arbLossFlag;
  logic shiftOutLatch, waitCancel, irq, wcSeen;
  int failCount = 0;
  int checkCount = 0;
  int cycles = 0;
  // open-drain data line with pull-up
  wire sdaIn = sdaDrv & (sdaOutEn_n | sdaOut);
  isf_status_top isf_status_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclLine), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOutEn_n(sdaOutEn_n), .masterRole(masterRole), .startGen(startGen),
    .arbLossFlag(arbLossFlag), .shiftOutLatch(shiftOutLatch), .waitCancel(waitCancel),
    .irq(irq));
  isf_bus_master_model isf_bus_master_model_i (.sclLine(sclLine), .sdaDrv(sdaDrv));
  task automatic closeOut();
    $display("checks %0d errors %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; pready is taken at the rising edge that ends the access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, exp);
  endtask
  function automatic logic [31:0] st(input logic d, a, s, p);
    st = 32'h0;
    st[STAT_DIR] = d;
    st[STAT_ACK] = a;
    st[STAT_START] = s;
    st[STAT_STOP] = p;
  endfunction
  // covers synchroniser, event and strobe latency
  task automatic settle();
    repeat (8) @(posedge core_clk);
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rchk("ctrl", OFS_CTRL, 32'h0);
    rchk("status", OFS_STAT, 32'h0);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped", {e, r[30:0]}, 32'h80000000);
    wreg(OFS_IRQ_MASK, 32'hF);
    rchk("mask", OFS_IRQ_MASK, 32'h7);
    wreg(OFS_IRQ_MASK, 32'h1);
    wreg(OFS_CTRL, EN | WR | EX);
    rchk("ctrl bits", OFS_CTRL, EN);
  endtask
  task automatic t_slave_tx();
    isf_bus_master_model_i.start_cond();
    settle();
    rchk("start", OFS_STAT, st(0, 0, 1, 0));
    chk("irq masked", {31'h0, irq}, 32'h0);
    isf_bus_master_model_i.send_byte(8'hA1, 1'b1);
    settle();
    rchk("addr rd", OFS_STAT, st(1, 1, 1, 0));
    chk("drive", {31'h0, sdaOutEn_n}, 32'h0);
    chk("drive level", {31'h0, sdaOut}, 32'h0);
    // a one in the latch must leave the open-drain line released
    shiftOutLatch <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("latch one", {31'h0, sdaOutEn_n}, 32'h1);
    shiftOutLatch <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("latch zero", {31'h0, sdaOutEn_n}, 32'h0);
    wreg(OFS_CTRL, EN | WR);
    settle();
    chk("cancel", {wcSeen, sdaOutEn_n}, 32'h3);
    rchk("wait rel", OFS_STAT, st(0, 1, 1, 0));
    isf_bus_master_model_i.send_byte(8'h55, 1'b0);
    settle();
    rchk("next byte", OFS_STAT, 32'h0);
    isf_bus_master_model_i.stop_cond();
    settle();
    rchk("stop", OFS_STAT, st(0, 0, 0, 1));
    chk("irq stop", {31'h0, irq}, 32'h1);
    rchk("events", OFS_IRQ_STAT, 32'h7);
    wreg(OFS_IRQ_STAT, 32'h1);
    rchk("w1c", OFS_IRQ_STAT, 32'h6);
    chk("irq clr", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_master();
    masterRole <= 1'b1;
    startGen <= 1'b1;
    @(posedge core_clk);
    startGen <= 1'b0;
    settle();
    rchk("gen start", OFS_STAT, st(1, 0, 0, 1));
    arbLossFlag <= 1'b1;
    settle();
    rchk("arb loss", OFS_STAT, st(0, 0, 0, 1));
    startGen <= 1'b1;
    @(posedge core_clk);
    startGen <= 1'b0;
    masterRole <= 1'b0;
    arbLossFlag <= 1'b0;
  endtask
  // direction left at one by the master hook, then a slave write
  task automatic t_slave_rx();
    isf_bus_master_model_i.start_cond();
    settle();
    rchk("held stop", OFS_STAT, st(0, 0, 1, 1));
    isf_bus_master_model_i.send_byte(8'hA0, 1'b0);
    settle();
    rchk("addr wr", OFS_STAT, st(0, 0, 1, 0));
    chk("released", {31'h0, sdaOutEn_n}, 32'h1);
    wreg(OFS_CTRL, EN | EX);
    settle();
    rchk("exit", OFS_STAT, 32'h0);
    isf_bus_master_model_i.stop_cond();
    wreg(OFS_CTRL, 32'h0);
    settle();
    rchk("disable", OFS_STAT, 32'h0);
  endtask
  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // reset, then the scenarios in order
  initial begin
    {sys_rst, clkEn, wcSeen} = 3'h7;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    {masterRole, startGen, arbLossFlag, shiftOutLatch} = 4'h0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    wcSeen <= 1'b0;
    t_regs();
    t_slave_tx();
    t_master();
    t_slave_rx();
    closeOut();
  end
  // catch the one-cycle cancel pulse and cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (waitCancel === 1'b1) wcSeen <= 1'b1;
    if (cycles == 20000) begin
      failCount++;
      closeOut();
    end
  end
endmodule // i2c_status_flag_logic_tb
`default_nettype wire
